// ---- verilog/ssrb_bank.sv ----
// status register bank: groups, error queue and avalon slave
// Summary of operation
// RL1: preset fills every positive filter with ones
// RL2: preset clears every negative filter
// RL3: preset clears operation and questionable enables
// RL4: instrument reset leaves status contents untouched
// RL5: queue read returns oldest entry, removes it
// RL6: empty queue reads error zero, no error
// RL7: positive device errors, negative language errors
// RL8: event read returns bits and clears them
// RL9: condition read is live, event untouched
// RL10: enabled event raises the group summary
// RL11: enable and filters hold sixteen bit values
// RL12: enabled falling condition sets event bit
// RL13: enabled rising condition sets event bit
// RL14: behaviour independent of measurement mode
// RL15: operation condition carries calibration state
// RL16: questionable condition carries oscillator, overload, limits
// RL17: service request from enabled status byte bits
// RL18: clear status empties events and queue only
// RL19: sub-group summaries feed questionable condition bits
// RL20: edges sampled per clock, events stay latched
`timescale 1ns/1ps
`default_nettype none
`include "ssrb_regs.svh"
module ssrb_bank
	import ssrb_pkg::*;
#(
	parameter int QDEPTH = 8
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	// avalon-mm slave
	input wire logic [7:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// live conditions: calibration state, oscillator/overload, sub-groups
	input wire logic [15:0] i_oper_cond,
	input wire logic [15:0] i_ques_cond,
	input wire logic [15:0] i_freq_cond,
	input wire logic [15:0] i_limt_cond,
	input wire logic [15:0] i_powr_cond,
	// error reports from the command parser, signed number
	input wire logic i_err_push,
	input wire logic [15:0] i_err_code,
	// summaries to the status byte
	output logic o_oper_summary,
	output logic o_ques_summary,
	output logic o_err_avail
);
	localparam int QW = $clog2(QDEPTH);
	localparam int NG = 5;

	// elaboration check on queue depth
	if (QDEPTH < 2 || QDEPTH > 256 || (1 << QW) != QDEPTH) begin : g_chk
		$error("QDEPTH must be a power of two from 2 to 256");
	end

	////////////////////////////////////////////////////////////////////
	// state
	typedef struct packed {
		ssrb_grp_t [NG-1:0] grp;
		logic [QDEPTH-1:0][15:0] qmem;
		logic [QW-1:0] qrd;
		logic [QW-1:0] qwr;
		logic [QW:0] qcnt;
		logic qovf;
		logic [31:0] rdata;
		ssrb_bus_st_t bst;
	} ssrb_state_t;

	ssrb_state_t st_q;
	ssrb_state_t st_d;

	logic [NG-1:0][15:0] cond; // live condition per group
	logic [NG-1:0] summ; // group summaries
	logic [15:0] ques_full; // questionable condition with sub summaries
	ssrb_req_t req;
	logic take; // request accepted this cycle
	logic [2:0] a_grp;
	logic [2:0] a_part;
	logic preset;
	logic cls;

	assign req = '{read: i_avs_read, write: i_avs_write,
		address: i_avs_address, writedata: i_avs_writedata};
	assign a_grp = req.address[7:5];
	assign a_part = req.address[4:2];
	assign take = (req.read || req.write) && st_q.bst == SSRB_IDLE;
	assign preset = take && req.write && a_grp == `SSRB_G_CTRL
		&& a_part == `SSRB_C_CMD && i_avs_byteenable[0]
		&& req.writedata[`SSRB_CMD_PRESET];
	assign cls = take && req.write && a_grp == `SSRB_G_CTRL
		&& a_part == `SSRB_C_CMD && i_avs_byteenable[0]
		&& req.writedata[`SSRB_CMD_CLS];

	////////////////////////////////////////////////////////////////////
	// summaries, sub-groups first so they can feed questionable
	// no mode input exists: every path below is mode independent RL14
	always_comb begin
		for (int g = 0; g < NG; g++) begin
			summ[g] = |(st_q.grp[g].evnt & st_q.grp[g].enab); // RL10
		end
		ques_full = i_ques_cond; // RL16
		ques_full[`SSRB_QB_FREQ] = summ[`SSRB_G_FREQ]; // RL19
		ques_full[`SSRB_QB_LIMT] = summ[`SSRB_G_LIMT]; // RL19
		ques_full[`SSRB_QB_POWR] = summ[`SSRB_G_POWR]; // RL19
		cond[`SSRB_G_OPER] = i_oper_cond; // RL15
		cond[`SSRB_G_QUES] = ques_full;
		cond[`SSRB_G_FREQ] = i_freq_cond;
		cond[`SSRB_G_LIMT] = i_limt_cond;
		cond[`SSRB_G_POWR] = i_powr_cond;
	end

	////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		logic [15:0] rise;
		logic [15:0] fall;
		logic [15:0] hit;
		logic pop;
		rise = '0;
		fall = '0;
		hit = '0;
		pop = 1'b0;
		st_d = st_q;
		// bus handshake: one wait cycle, answer in the next
		case (st_q.bst)
			SSRB_IDLE: begin
				if (take) begin
					st_d.bst = SSRB_DONE;
				end
			end
			SSRB_DONE: begin
				st_d.bst = SSRB_IDLE;
			end
			default: begin
				st_d.bst = SSRB_IDLE;
			end
		endcase
		// edge filters, once per clock against last sample
		for (int g = 0; g < NG; g++) begin
			rise = cond[g] & ~st_q.grp[g].cond_prev;
			fall = ~cond[g] & st_q.grp[g].cond_prev;
			hit = (rise & st_q.grp[g].ptrf) // RL13
				| (fall & st_q.grp[g].ntrf); // RL12
			st_d.grp[g].cond_prev = cond[g]; // RL20
			// read of event clears; a new edge in the same cycle wins
			if (take && req.read && a_grp == 3'(g)
				&& a_part == `SSRB_P_EVNT) begin
				st_d.grp[g].evnt = hit; // RL8
			end else if (cls) begin
				st_d.grp[g].evnt = hit; // RL18
			end else begin
				st_d.grp[g].evnt = st_q.grp[g].evnt | hit; // RL20
			end
			// software writes, sixteen bit fields only RL11
			if (take && req.write && a_grp == 3'(g)) begin
				case (a_part)
					`SSRB_P_ENAB: st_d.grp[g].enab = req.writedata[15:0];
					`SSRB_P_PTRF: st_d.grp[g].ptrf = req.writedata[15:0];
					`SSRB_P_NTRF: st_d.grp[g].ntrf = req.writedata[15:0];
					default: begin
					end
				endcase
			end
			if (preset) begin
				st_d.grp[g].ptrf = `SSRB_PTR_PRESET; // RL1
				st_d.grp[g].ntrf = `SSRB_NTR_PRESET; // RL2
				// only the two top groups are silenced; sub-groups
				// open up so their summaries reach questionable
				st_d.grp[g].enab = (g <= int'(`SSRB_G_QUES))
					? `SSRB_ENA_PRESET // RL3
					: `SSRB_SUB_ENA_PRESET;
			end
		end
		// the instrument reset command bit is accepted and ignored RL4
		// read data, captured at acceptance
		if (take && req.read) begin
			st_d.rdata = `SSRB_UNMAPPED;
			if (a_grp < 3'(NG)) begin
				case (a_part)
					`SSRB_P_COND: st_d.rdata = {16'h0000, cond[a_grp]}; // RL9
					`SSRB_P_EVNT: st_d.rdata = {16'h0000, st_q.grp[a_grp].evnt};
					`SSRB_P_ENAB: st_d.rdata = {16'h0000, st_q.grp[a_grp].enab};
					`SSRB_P_PTRF: st_d.rdata = {16'h0000, st_q.grp[a_grp].ptrf};
					`SSRB_P_NTRF: st_d.rdata = {16'h0000, st_q.grp[a_grp].ntrf};
					default: st_d.rdata = `SSRB_UNMAPPED;
				endcase
			end else if (a_grp == `SSRB_G_CTRL && a_part == `SSRB_C_QUEUE) begin
				// oldest entry; zero means no error RL5 RL6
				if (st_q.qcnt != '0) begin
					st_d.rdata = {16'h0000, st_q.qmem[st_q.qrd]}; // RL5
					pop = 1'b1;
				end else begin
					st_d.rdata = {16'h0000, `SSRB_ERR_NONE}; // RL6
				end
			end else if (a_grp == `SSRB_G_CTRL && a_part == `SSRB_C_STAT) begin
				st_d.rdata = {16'h0000, 7'h00, st_q.qovf, 8'(st_q.qcnt)};
			end
		end
		// error queue; codes keep their sign as given RL7
		if (cls) begin
			st_d.qrd = '0; // RL18
			st_d.qwr = '0;
			st_d.qcnt = '0;
			st_d.qovf = 1'b0;
		end else begin
			if (pop) begin
				st_d.qrd = st_q.qrd + 1'b1;
			end
			// a push on a full queue is dropped and flagged, unless a queue read pops in the same cycle
			if (i_err_push && i_err_code != `SSRB_ERR_NONE) begin
				if (st_q.qcnt == (QW+1)'(QDEPTH) && !pop) begin
					st_d.qovf = 1'b1;
				end else begin
					st_d.qmem[st_q.qwr] = i_err_code; // RL7
					st_d.qwr = st_q.qwr + 1'b1;
				end
			end
			st_d.qcnt = st_q.qcnt + (st_d.qwr != st_q.qwr ? 1'b1 : 1'b0)
				- (pop ? 1'b1 : 1'b0);
		end
	end

	////////////////////////////////////////////////////////////////////
	// registers; preset defaults after reset, except sub-group enables, which reset to zero
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			st_q <= '0;
			st_q.bst <= SSRB_IDLE;
			for (int g = 0; g < NG; g++) begin
				st_q.grp[g].ptrf <= `SSRB_PTR_PRESET;
			end
		end else begin
			st_q <= st_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// outputs
	assign o_avs_waitrequest = (i_avs_read || i_avs_write)
		&& st_q.bst != SSRB_DONE;
	assign o_avs_readdata = st_q.rdata;
	// service request is formed from these bits at the status byte RL17
	assign o_oper_summary = summ[`SSRB_G_OPER];
	assign o_ques_summary = summ[`SSRB_G_QUES];
	assign o_err_avail = st_q.qcnt != '0;

	////////////////////////////////////////////////////////////////////
	// checks
	// these, all but AST_SUMMARY, watch registered state one cycle after the strobe, so a
	// broken next-state path shows up even when the bench misses it

	// preset fills the operation positive filter
	AST_PRESET_PTR: assert property ( // RL1
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		preset |=> st_q.grp[0].ptrf == `SSRB_PTR_PRESET
	) else $error("preset did not fill positive filter");

	// preset clears the questionable negative filter
	AST_PRESET_NTR: assert property ( // RL2
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		preset |=> st_q.grp[1].ntrf == `SSRB_NTR_PRESET
	) else $error("preset did not clear negative filter");

	// preset silences operation and questionable
	AST_PRESET_ENA: assert property ( // RL3
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		preset |=> st_q.grp[0].enab == '0 && st_q.grp[1].enab == '0
	) else $error("preset did not clear enables");

	// empty queue answers with error zero
	AST_EMPTY_Q: assert property ( // RL6
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		take && req.read && a_grp == `SSRB_G_CTRL
		&& a_part == `SSRB_C_QUEUE && st_q.qcnt == '0
		|=> st_q.rdata == 32'h0000_0000
	) else $error("empty queue read not zero");

	// a queue read removes exactly one entry
	AST_POP: assert property ( // RL5
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		take && req.read && a_grp == `SSRB_G_CTRL
		&& a_part == `SSRB_C_QUEUE && st_q.qcnt != '0
		&& !i_err_push && !cls
		|=> st_q.qcnt == $past(st_q.qcnt) - 1'b1
	) else $error("queue read did not remove entry");

	// enabled operation event reaches the summary
	AST_SUMMARY: assert property ( // RL10
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		|(st_q.grp[0].evnt & st_q.grp[0].enab) |-> o_oper_summary
	) else $error("operation summary missing");

	// filtered rising edge latches
	AST_RISE: assert property ( // RL13
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_oper_cond[0] && !st_q.grp[0].cond_prev[0]
		&& st_q.grp[0].ptrf[0]) |=> st_q.grp[0].evnt[0]
	) else $error("rising edge not latched");

	// filtered falling edge latches
	AST_FALL: assert property ( // RL12
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(!i_oper_cond[0] && st_q.grp[0].cond_prev[0]
		&& st_q.grp[0].ntrf[0]) |=> st_q.grp[0].evnt[0]
	) else $error("falling edge not latched");

	// clear status empties the queue and its overflow flag
	AST_CLS: assert property ( // RL18
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		cls |=> st_q.qcnt == '0 && !st_q.qovf
	) else $error("clear status left queue");

	// accepted request is answered in the following cycle
	AST_ANSWER: assert property (
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		take |=> !o_avs_waitrequest
	) else $error("bus answer late");

	// condition read returns the live bits it saw
	AST_COND_LIVE: assert property ( // RL9
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		take && req.read && a_grp == `SSRB_G_OPER
		&& a_part == `SSRB_P_COND
		|=> st_q.rdata == {16'h0000, $past(i_oper_cond)}
	) else $error("condition read not live");

	// event read with no new edge leaves the part empty
	AST_RD_CLR: assert property ( // RL8
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		take && req.read && a_grp == `SSRB_G_OPER
		&& a_part == `SSRB_P_EVNT && i_oper_cond == st_q.grp[0].cond_prev
		|=> st_q.grp[0].evnt == '0
	) else $error("event read did not clear");

	// an event bit stays until read or clear status
	AST_EVT_HOLD: assert property ( // RL20
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		st_q.grp[0].evnt[0] && !cls && !(take && req.read
		&& a_grp == `SSRB_G_OPER && a_part == `SSRB_P_EVNT)
		|=> st_q.grp[0].evnt[0]
	) else $error("event bit lost");

	// a rising frequency summary lands as a questionable event
	AST_SUB_FEED: assert property ( // RL19
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		summ[`SSRB_G_FREQ] && !st_q.grp[1].cond_prev[`SSRB_QB_FREQ]
		&& st_q.grp[1].ptrf[`SSRB_QB_FREQ]
		|=> st_q.grp[1].evnt[`SSRB_QB_FREQ]
	) else $error("sub-group summary not fed upward");
endmodule
`default_nettype wire

// ---- verilog/ssrb_regs.svh ----
// register map and constants of the status register bank
`ifndef SSRB_REGS_SVH
`define SSRB_REGS_SVH
// group indices: operation, questionable, frequency, limit, power
`define SSRB_G_OPER 3'h0
`define SSRB_G_QUES 3'h1
`define SSRB_G_FREQ 3'h2
`define SSRB_G_LIMT 3'h3
`define SSRB_G_POWR 3'h4
// part selector within a group, address bits [4:2]
`define SSRB_P_COND 3'h0
`define SSRB_P_EVNT 3'h1
`define SSRB_P_ENAB 3'h2
`define SSRB_P_PTRF 3'h3
`define SSRB_P_NTRF 3'h4
// control and queue words in group slot 5
`define SSRB_G_CTRL 3'h5
`define SSRB_C_CMD 3'h0
`define SSRB_C_QUEUE 3'h1
`define SSRB_C_STAT 3'h2
// command word bits
`define SSRB_CMD_PRESET 0
`define SSRB_CMD_CLS 1
`define SSRB_CMD_RST 2
// questionable condition bits fed by the sub-group summaries
`define SSRB_QB_FREQ 5
`define SSRB_QB_LIMT 9
`define SSRB_QB_POWR 3
// preset and reset values
`define SSRB_PTR_PRESET 16'hFFFF
`define SSRB_NTR_PRESET 16'h0000
`define SSRB_ENA_PRESET 16'h0000
`define SSRB_SUB_ENA_PRESET 16'hFFFF
`define SSRB_ERR_NONE 16'h0000
`define SSRB_UNMAPPED 32'h0000_0000
`endif

// ---- verilog/ssrb_pkg.sv ----
// types of the status register bank
package ssrb_pkg;
	// one status group: condition history, event, enable, filters
	typedef struct packed {
		logic [15:0] cond_prev;
		logic [15:0] evnt;
		logic [15:0] enab;
		logic [15:0] ptrf;
		logic [15:0] ntrf;
	} ssrb_grp_t;
	// avalon request bundle
	typedef struct packed {
		logic read;
		logic write;
		logic [7:0] address;
		logic [31:0] writedata;
	} ssrb_req_t;
	// bus handshake state
	typedef enum logic [1:0] {
		SSRB_IDLE = 2'b01,
		SSRB_DONE = 2'b10
	} ssrb_bus_st_t;
endpackage

// ---- testbench/ssrb_host_model.sv ----
// avalon-mm master model standing in for the remote controller
`timescale 1ns/1ps
`default_nettype none
module ssrb_host_model (
	input wire logic i_sys_clk,
	input wire logic [31:0] i_readdata,
	input wire logic i_waitrequest,
	output logic [7:0] o_address,
	output logic o_read,
	output logic o_write,
	output logic [31:0] o_writedata,
	output logic [3:0] o_byteenable
);
	// idle bus from time zero
	initial begin
		o_address = 8'h00;
		o_read = 1'b0;
		o_write = 1'b0;
		o_writedata = 32'h0000_0000;
		o_byteenable = 4'hF;
	end
	////////////////////////////////////////////////////////////////////////
	// one transfer, held until waitrequest is low; the wait is bounded
	task automatic xfer(input logic wr, input logic [7:0] a,
		input logic [15:0] d, output logic [31:0] q, output logic ok);
		int n;
		@(posedge i_sys_clk);
		o_address <= a;
		o_writedata <= {16'h0000, d};
		o_read <= !wr;
		o_write <= wr;
		ok = 1'b0;
		q = 32'h0000_0000;
		for (n = 0; n < 64 && !ok; n++) begin
			@(posedge i_sys_clk);
			if (i_waitrequest === 1'b0) begin
				ok = 1'b1;
				q = i_readdata;
			end
		end
		// released data shows the inverse so stale values never match
		o_read <= 1'b0;
		o_write <= 1'b0;
		o_writedata <= ~{16'h0000, d};
	endtask
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
// self-checking bench of the status register bank
`timescale 1ns/1ps
`default_nettype none
`include "ssrb_regs.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module testbench;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] addr;
	logic rd, wr_s, wait_s;
	logic [31:0] wdata, rdata;
	logic [3:0] be;
	logic [15:0] c_op = 16'h0, c_qu = 16'h0, c_fr = 16'h0;
	logic [15:0] c_li = 16'h0, c_po = 16'h0, e_code = 16'h0;
	logic e_push = 1'b0;
	logic s_op, s_qu, e_av;
	int n_fail = 0;
	int compares = 0;
	// 125 MHz system clock
	always #4 clk = ~clk;
	ssrb_bank ssrb_bank_i (.i_sys_clk(clk), .i_rst_n(rst_n),
		.i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr_s),
		.i_avs_writedata(wdata), .i_avs_byteenable(be),
		.o_avs_readdata(rdata), .o_avs_waitrequest(wait_s),
		.i_oper_cond(c_op), .i_ques_cond(c_qu), .i_freq_cond(c_fr),
		.i_limt_cond(c_li), .i_powr_cond(c_po), .i_err_push(e_push),
		.i_err_code(e_code), .o_oper_summary(s_op),
		.o_ques_summary(s_qu), .o_err_avail(e_av));
	ssrb_host_model ssrb_host_model_i (.i_sys_clk(clk), .i_readdata(rdata),
		.i_waitrequest(wait_s), .o_address(addr), .o_read(rd),
		.o_write(wr_s), .o_writedata(wdata), .o_byteenable(be));
	////////////////////////////////////////////////////////////////////////
	// verdict and end of run, also reached by a timed-out bus wait
	task automatic finish_test();
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// bus access at group g, part p; a timeout ends the run
	task automatic bus(input logic w, input logic [2:0] g, input logic [2:0] p,
		input logic [15:0] d, output logic [31:0] q);
		logic ok;
		ssrb_host_model_i.xfer(w, {g, p, 2'b00}, d, q, ok);
		if (!ok) begin
			n_fail++;
			finish_test();
		end
	endtask
	task automatic wr(input logic [2:0] g, p, input logic [15:0] d);
		logic [31:0] q;
		bus(1'b1, g, p, d, q);
	endtask
	// read and compare; upper half must read zero
	task automatic rdc(input logic [2:0] g, p, input logic [15:0] e);
		logic [31:0] q;
		bus(1'b0, g, p, 16'h0000, q);
		`CHK(q, {16'h0000, e})
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// one-cycle error report pulse
	task automatic push(input logic [15:0] c);
		@(posedge clk);
		e_push <= 1'b1;
		e_code <= c;
		@(posedge clk);
		e_push <= 1'b0;
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_preset();
		rdc(`SSRB_G_OPER, `SSRB_P_PTRF, 16'hFFFF);
		rdc(`SSRB_G_QUES, `SSRB_P_NTRF, 16'h0000);
		wr(`SSRB_G_OPER, `SSRB_P_NTRF, 16'h1234);
		wr(`SSRB_G_QUES, `SSRB_P_PTRF, 16'h0000);
		wr(`SSRB_G_QUES, `SSRB_P_ENAB, 16'h00FF);
		wr(`SSRB_G_FREQ, `SSRB_P_ENAB, 16'h0000);
		wr(`SSRB_G_CTRL, `SSRB_C_CMD, 16'h0001);
		rdc(`SSRB_G_QUES, `SSRB_P_PTRF, 16'hFFFF);
		rdc(`SSRB_G_OPER, `SSRB_P_NTRF, 16'h0000);
		rdc(`SSRB_G_QUES, `SSRB_P_ENAB, 16'h0000);
		rdc(`SSRB_G_FREQ, `SSRB_P_ENAB, 16'hFFFF);
		// instrument reset command must leave the registers alone
		wr(`SSRB_G_OPER, `SSRB_P_ENAB, 16'h5A5A);
		wr(`SSRB_G_CTRL, `SSRB_C_CMD, 16'h0004);
		rdc(`SSRB_G_OPER, `SSRB_P_ENAB, 16'h5A5A);
		$display("test preset done");
	endtask
	// bit0 rises (positive filter), bit1 rises then falls (negative)
	task automatic t_edges();
		wr(`SSRB_G_OPER, `SSRB_P_PTRF, 16'h0001);
		wr(`SSRB_G_OPER, `SSRB_P_NTRF, 16'h0002);
		wr(`SSRB_G_OPER, `SSRB_P_ENAB, 16'h0001);
		wr(`SSRB_G_OPER, `SSRB_P_EVNT, 16'hFFFF);
		c_op <= 16'h0003;
		cyc(3);
		`CHK(s_op, 1'b1)
		c_op <= 16'h0001;
		cyc(3);
		rdc(`SSRB_G_OPER, `SSRB_P_COND, 16'h0001);
		rdc(`SSRB_G_OPER, `SSRB_P_EVNT, 16'h0003);
		rdc(`SSRB_G_OPER, `SSRB_P_EVNT, 16'h0000);
		cyc(1);
		`CHK(s_op, 1'b0)
		$display("test edges done");
	endtask
	// sub-group summaries land on questionable bits 5, 9 and 3
	task automatic t_sub();
		wr(`SSRB_G_CTRL, `SSRB_C_CMD, 16'h0001);
		c_fr <= 16'h0001;
		c_li <= 16'h0100;
		c_po <= 16'h8000;
		cyc(4);
		rdc(`SSRB_G_QUES, `SSRB_P_COND, 16'h0228);
		`CHK(s_qu, 1'b0)
		wr(`SSRB_G_QUES, `SSRB_P_ENAB, 16'h0020);
		cyc(1);
		`CHK(s_qu, 1'b1)
		rdc(`SSRB_G_FREQ, `SSRB_P_EVNT, 16'h0001);
		$display("test subgroup done");
	endtask
	task automatic t_queue();
		rdc(`SSRB_G_CTRL, `SSRB_C_QUEUE, 16'h0000);
		push(16'hFFFB);
		push(16'h0007);
		cyc(1);
		`CHK(e_av, 1'b1)
		rdc(`SSRB_G_CTRL, `SSRB_C_STAT, 16'h0002);
		rdc(`SSRB_G_CTRL, `SSRB_C_QUEUE, 16'hFFFB);
		rdc(`SSRB_G_CTRL, `SSRB_C_QUEUE, 16'h0007);
		rdc(`SSRB_G_CTRL, `SSRB_C_QUEUE, 16'h0000);
		`CHK(e_av, 1'b0)
		$display("test queue done");
	endtask
	// clear-status empties events and queue, keeps the enables
	task automatic t_cls();
		push(16'h0011);
		c_op <= 16'h0011;
		cyc(3);
		wr(`SSRB_G_CTRL, `SSRB_C_CMD, 16'h0002);
		rdc(`SSRB_G_OPER, `SSRB_P_EVNT, 16'h0000);
		rdc(`SSRB_G_QUES, `SSRB_P_ENAB, 16'h0020);
		rdc(`SSRB_G_CTRL, `SSRB_C_QUEUE, 16'h0000);
		rdc(3'h7, 3'h0, 16'h0000);
		$display("test clear status done");
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		cyc(2);
		rst_n <= 1'b1;
		t_preset();
		t_edges();
		t_sub();
		t_queue();
		t_cls();
		finish_test();
	end
endmodule
`default_nettype wire
